// *** verilog/wakeup_timer_cfg.svh ***
// Offsets, field positions, reset values and widths of the wake-up timer
`ifndef WAKEUP_TIMER_CFG_SVH
`define WAKEUP_TIMER_CFG_SVH
`define WT_OFS_CONTROL 8'h00
`define WT_OFS_RELOAD 8'h04
`define WT_OFS_COUNT 8'h08
`define WT_OFS_IRQ_ENABLE 8'h10
`define WT_OFS_FLAGS 8'h14
`define WT_OFS_FLAG_CLEAR 8'h1c
`define WT_ADDR_BITS 8
`define WT_EN_BIT 0
`define WT_MODE_LSB 1
`define WT_MODE_MSB 2
`define WT_PRS_LSB 4
`define WT_PRS_MSB 7
`define WT_SRC_LSB 8
`define WT_SRC_MSB 10
`define WT_UD_BIT 3
`define WT_CONTROL_RESET 11'h000
`define WT_RELOAD_RESET 16'hffff
`define WT_COUNT_RESET 16'h0000
`define WT_PRE_BITS 15
`define WT_SRC_COUNT 5
`endif

// *** verilog/wakeup_timer_pkg.sv ***
// Types shared by the wake-up timer design
package wakeup_timer_pkg;
   // Order gives the source-select codes 000 to 100
   typedef enum logic [2:0] {
      src_fast_osc,
      src_slow_osc,
      src_ext_a,
      src_ext_b,
      src_event
   } source_select_e;
   typedef logic [3:0] prescale_code_t;
   typedef logic [15:0] down_count_t;
endpackage

// *** verilog/auto_wakeup_down_timer.sv ***
// Auto-reload wake-up down timer with AHB-Lite register slave
`include "wakeup_timer_cfg.svh"
`timescale 1ns/1ps
module auto_wakeup_down_timer (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic hready_in,
   input wire logic [31:0] hwdata_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic fast_internal_osc_in,
   input wire logic slow_internal_osc_in,
   input wire logic ext_clock_in_a_in,
   input wire logic ext_clock_in_b_in,
   input wire logic event_input_pin_in,
   input wire logic deep_low_power_state_in,
   input wire logic debug_state_in,
   input wire logic debug_freeze_control_in,
   output logic irq_out,
   output logic wakeup_out,
   output wakeup_timer_pkg::down_count_t down_count_out
);
   import wakeup_timer_pkg::*;

   // Bus capture of the address phase
   logic wr_pending;
   logic [`WT_ADDR_BITS-1:0] addr_q;
   logic next_wr_pending;
   logic [`WT_ADDR_BITS-1:0] next_addr_q;
   logic addr_take;

   // Software visible state
   logic [10:0] timer_control;
   down_count_t reload_value;
   logic irq_enable;
   logic underflow_flag;
   logic [31:0] read_data;
   logic [10:0] next_timer_control;
   down_count_t next_reload_value;
   logic next_irq_enable;
   logic next_underflow_flag;
   logic [31:0] next_read_data;

   // Counting state
   down_count_t down_count;
   logic [`WT_PRE_BITS-1:0] pre_count;
   down_count_t next_down_count;
   logic [`WT_PRE_BITS-1:0] next_pre_count;

   // Source synchronizers
   logic [`WT_SRC_COUNT-1:0] src_raw;
   logic [`WT_SRC_COUNT-1:0] sync_a;
   logic [`WT_SRC_COUNT-1:0] sync_b;
   logic [`WT_SRC_COUNT-1:0] sync_c;
   logic [`WT_SRC_COUNT-1:0] src_rise;

   // Decoded helpers
   logic timer_enable;
   source_select_e source_select;
   prescale_code_t prescale_code;
   logic [`WT_PRE_BITS-1:0] pre_mask;
   logic src_tick;
   logic divided_count_clock;
   logic count_allowed;
   logic debug_hold;
   logic sleep_hold;
   logic enable_rise;
   logic underflow_event;
   logic wr_control;
   logic wr_reload;
   logic wr_irq_enable;
   logic wr_flag_clear;

   assign src_raw = {event_input_pin_in, ext_clock_in_b_in, ext_clock_in_a_in,
                     slow_internal_osc_in, fast_internal_osc_in};

   // Each source level must last a full clock or its edge is lost
   // First stage feeds only the second; edges come from stages two and three
   genvar gi;
   generate
      for (gi = 0; gi < `WT_SRC_COUNT; gi++) begin : g_sync
         always_ff @(posedge clock_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               sync_a[gi] <= 1'b0;
               sync_b[gi] <= 1'b0;
               sync_c[gi] <= 1'b0;
            end else begin
               sync_a[gi] <= src_raw[gi];
               sync_b[gi] <= sync_a[gi];
               sync_c[gi] <= sync_b[gi];
            end
         end
         assign src_rise[gi] = sync_b[gi] & ~sync_c[gi];
      end
   endgenerate

   assign timer_enable = timer_control[`WT_EN_BIT];
   assign source_select = source_select_e'(timer_control[`WT_SRC_MSB:`WT_SRC_LSB]);
   assign prescale_code = timer_control[`WT_PRS_MSB:`WT_PRS_LSB];

   // Codes above 100 select nothing, so the counter sees no ticks
   always_comb begin
      src_tick = 1'b0;
      unique case (source_select)
         src_fast_osc: src_tick = src_rise[0];
         src_slow_osc: src_tick = src_rise[1];
         src_ext_a: src_tick = src_rise[2];
         src_ext_b: src_tick = src_rise[3];
         src_event: src_tick = src_rise[4];
         default: src_tick = 1'b0;
      endcase
   end

   // Reserved code zero is treated as divide by two
   always_comb begin
      if (prescale_code == 4'h0) begin
         pre_mask = `WT_PRE_BITS'(1);
      end else begin
         pre_mask = `WT_PRE_BITS'((16'h0001 << prescale_code) - 16'h0001);
      end
   end

   // Debug freeze is a plain input; no register holds it
   assign debug_hold = debug_state_in & debug_freeze_control_in;
   // Only the slow oscillator keeps running in deep sleep
   assign sleep_hold = deep_low_power_state_in && source_select != src_slow_osc;
   // Held count keeps its value, so counting resumes where it stopped
   assign count_allowed = timer_enable & ~debug_hold & ~sleep_hold;

   assign divided_count_clock = count_allowed & src_tick
      & ((pre_count & pre_mask) == pre_mask);
   assign underflow_event = divided_count_clock && down_count == 16'h0000;

   // Bus address phase
   assign addr_take = hsel_in & htrans_in[1] & hready_in;
   // Zero wait states; every transfer answers OKAY
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;

   always_comb begin
      next_wr_pending = addr_take & hwrite_in;
      next_addr_q = addr_q;
      if (addr_take) begin
         next_addr_q = haddr_in[`WT_ADDR_BITS-1:0];
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_pending <= 1'b0;
         addr_q <= '0;
      end else begin
         wr_pending <= next_wr_pending;
         addr_q <= next_addr_q;
      end
   end

   // Data-phase write strobes; unmapped offsets give none
   always_comb begin
      wr_control = 1'b0;
      wr_reload = 1'b0;
      wr_irq_enable = 1'b0;
      wr_flag_clear = 1'b0;
      enable_rise = 1'b0;
      if (wr_pending) begin
         unique case (addr_q)
            `WT_OFS_CONTROL: begin
               wr_control = 1'b1;
               // Only a 0 to 1 change reloads; rewriting enable keeps the count
               enable_rise = hwdata_in[`WT_EN_BIT] & ~timer_enable;
            end
            `WT_OFS_RELOAD: wr_reload = 1'b1;
            `WT_OFS_IRQ_ENABLE: wr_irq_enable = 1'b1;
            `WT_OFS_FLAG_CLEAR: wr_flag_clear = 1'b1;
            default: wr_control = 1'b0;
         endcase
      end
   end

   // Register file; read data is fetched in the address phase
   always_comb begin
      next_timer_control = timer_control;
      next_reload_value = reload_value;
      next_irq_enable = irq_enable;
      next_underflow_flag = underflow_flag;
      next_read_data = read_data;
      if (wr_control) begin
         next_timer_control = hwdata_in[10:0];
         // Reserved bit 3 is never stored, so it reads zero
         next_timer_control[3] = 1'b0;
      end
      if (wr_reload) begin
         next_reload_value = hwdata_in[15:0];
      end
      if (wr_irq_enable) begin
         next_irq_enable = hwdata_in[`WT_UD_BIT];
      end
      if (wr_flag_clear && !hwdata_in[`WT_UD_BIT]) begin
         next_underflow_flag = 1'b0;
      end
      // A new underflow beats a clear in the same cycle
      if (underflow_event) begin
         next_underflow_flag = 1'b1;
      end
      if (addr_take && !hwrite_in) begin
         next_read_data = 32'h0000_0000;
         unique case (haddr_in[`WT_ADDR_BITS-1:0])
            `WT_OFS_CONTROL: next_read_data[10:0] = next_timer_control;
            `WT_OFS_RELOAD: next_read_data[15:0] = next_reload_value;
            `WT_OFS_COUNT: next_read_data[15:0] = next_down_count;
            `WT_OFS_IRQ_ENABLE: next_read_data[`WT_UD_BIT] = next_irq_enable;
            `WT_OFS_FLAGS: next_read_data[`WT_UD_BIT] = next_underflow_flag;
            default: next_read_data = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         timer_control <= `WT_CONTROL_RESET;
         reload_value <= `WT_RELOAD_RESET;
         irq_enable <= 1'b0;
         underflow_flag <= 1'b0;
         read_data <= 32'h0000_0000;
      end else begin
         timer_control <= next_timer_control;
         reload_value <= next_reload_value;
         irq_enable <= next_irq_enable;
         underflow_flag <= next_underflow_flag;
         read_data <= next_read_data;
      end
   end

   // Counter and prescaler
   always_comb begin
      next_down_count = down_count;
      next_pre_count = pre_count;
      // Enable load wins over a tick in the same cycle
      if (enable_rise) begin
         next_down_count = reload_value;
         next_pre_count = '0;
      end else if (count_allowed) begin
         if (src_tick) begin
            next_pre_count = pre_count + `WT_PRE_BITS'(1);
         end
         // Current reload value is used, so a late write waits one period
         if (underflow_event) begin
            next_down_count = reload_value;
         end else if (divided_count_clock) begin
            next_down_count = down_count - 16'h0001;
         end
      end else if (!timer_enable) begin
         // Phase restarts cleanly at the next enable
         next_pre_count = '0;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         down_count <= `WT_COUNT_RESET;
         pre_count <= '0;
      end else begin
         down_count <= next_down_count;
         pre_count <= next_pre_count;
      end
   end

   assign hrdata_out = read_data;
   assign down_count_out = down_count;
   assign irq_out = underflow_flag & irq_enable;
   // Wake request is the interrupt qualified by deep sleep
   assign wakeup_out = underflow_flag & irq_enable & deep_low_power_state_in;

endmodule // auto_wakeup_down_timer

// *** verif/auto_wakeup_down_timer_checker.sv ***
// Bus, count and interrupt checks for the wake-up timer
`timescale 1ns/1ps
module auto_wakeup_down_timer_checker
   import wakeup_timer_pkg::*;
(
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic hready_in,
   input wire logic [31:0] hwdata_in,
   input wire logic [31:0] hrdata_out,
   input wire logic hreadyout_out,
   input wire logic hresp_out,
   input wire logic deep_low_power_state_in,
   input wire logic irq_out,
   input wire logic wakeup_out,
   input wire wakeup_timer_pkg::down_count_t down_count_out
);
   logic take, rd, wr_pend, en_q;
   logic [7:0] wr_addr;
   logic [15:0] reload_q;
   assign take = hsel_in && htrans_in[1] && hready_in;
   assign rd = take && !hwrite_in;
   // Shadow of enable and reload, updated at the data-phase edge
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         en_q <= 1'b0;
         reload_q <= 16'hffff;
      end else begin
         wr_pend <= take && hwrite_in;
         wr_addr <= take ? haddr_in[7:0] : wr_addr;
         en_q <= (wr_pend && wr_addr == 8'h00) ? hwdata_in[0] : en_q;
         reload_q <= (wr_pend && wr_addr == 8'h04) ? hwdata_in[15:0] : reload_q;
      end
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   a_bus_okay: assert property (hreadyout_out == 1'b1 && hresp_out == 1'b0)
      else $error("bus answer not ready or not okay");
   a_wake_level: assert property (wakeup_out == (irq_out && deep_low_power_state_in))
      else $error("wakeup output wrong");
   a_count_hold: assert property ((!en_q && !wr_pend) |=> $stable(down_count_out))
      else $error("count moved while disabled");
   a_count_step: assert property ((en_q && !wr_pend) |=> $stable(down_count_out) ||
      ($past(down_count_out) != 16'h0 && down_count_out == $past(down_count_out) - 16'h1) ||
      ($past(down_count_out) == 16'h0 && down_count_out == $past(reload_q)))
      else $error("count step wrong");
   a_irq_cause: assert property ($rose(irq_out) |-> $past(down_count_out) == 16'h0 ||
      $past(wr_pend)) else $error("irq rose without underflow");
   a_unmapped_zero: assert property ((rd && haddr_in[7:0] inside {8'h0c, 8'h18, 8'h1c})
      |=> hrdata_out == 32'h0) else $error("unmapped read not zero");
   a_count_read: assert property ((rd && haddr_in[7:0] == 8'h08)
      |=> hrdata_out == {16'h0, down_count_out}) else $error("count read wrong");
   a_reload_read: assert property ((rd && haddr_in[7:0] == 8'h04 && !wr_pend)
      |=> hrdata_out == {16'h0, $past(reload_q)}) else $error("reload read wrong");
endmodule // auto_wakeup_down_timer_checker
bind auto_wakeup_down_timer auto_wakeup_down_timer_checker chk (.clock_in, .rst_n_in,
   .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hready_in, .hwdata_in, .hrdata_out,
   .hreadyout_out, .hresp_out, .deep_low_power_state_in, .irq_out, .wakeup_out,
   .down_count_out);

// *** verif/source_clock_model.sv ***
// Pulse source standing in for the oscillators and external pins
`timescale 1ns/1ps
module source_clock_model (
   input wire logic clock_in,
   input wire logic [2:0] which_in,
   input wire logic pulse_in,
   output logic [4:0] src_out
);
   logic [2:0] phase = 3'h0;
   // One edge a request, high two and low three cycles, inside the sync limit
   always_ff @(posedge clock_in) begin
      if (pulse_in && phase == 3'h0) begin
         phase <= 3'h4;
      end else if (phase != 3'h0) begin
         phase <= phase - 3'h1;
      end
   end
   // Lines rest low between requests; only the chosen one moves
   assign src_out = (phase > 3'h2) ? (5'h01 << which_in) : 5'h00;
endmodule // source_clock_model

// *** verif/auto_wakeup_down_timer_tb.sv ***
// Register-level testbench of the wake-up timer
`timescale 1ns/1ps
module auto_wakeup_down_timer_tb;
   import wakeup_timer_pkg::*;
   logic clock_in = 0, rst_n_in = 0, hsel = 0, hwrite = 0, pulse = 0, deep = 0, dbg = 0, frz = 0;
   logic [1:0] htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata_out;
   logic [2:0] which = 0;
   logic [4:0] src;
   logic hreadyout_out, hresp_out, irq_out, wakeup_out;
   down_count_t down_count_out;
   int num_errors = 0, total_checks = 0;
   always #4 clock_in = ~clock_in;
   auto_wakeup_down_timer uut (.clock_in, .rst_n_in, .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hreadyout_out),
      .hwdata_in(hwdata), .hrdata_out, .hreadyout_out, .hresp_out,
      .fast_internal_osc_in(src[0]), .slow_internal_osc_in(src[1]), .ext_clock_in_a_in(src[2]),
      .ext_clock_in_b_in(src[3]), .event_input_pin_in(src[4]), .deep_low_power_state_in(deep),
      .debug_state_in(dbg), .debug_freeze_control_in(frz), .irq_out, .wakeup_out,
      .down_count_out);
   source_clock_model model (.clock_in, .which_in(which), .pulse_in(pulse), .src_out(src));
   task check(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      hsel <= 1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clock_in); while (hreadyout_out !== 1'b1);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock_in); while (hreadyout_out !== 1'b1);
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] exp, input string name);
      bus(0, a, 0);
      check(name, exp, hrdata_out);
   endtask
   // Extra cycles at the end let the last edge clear the synchroniser
   task edges(input int n);
      repeat (n) begin
         @(posedge clock_in);
         pulse <= 1;
         @(posedge clock_in);
         pulse <= 0;
         repeat (4) @(posedge clock_in);
      end
      repeat (4) @(posedge clock_in);
   endtask
   // Disable first so source and prescale never change while running
   task cfg(input logic [2:0] s, input logic [3:0] p, input logic [15:0] r);
      bus(1, 8'h00, 0);
      bus(1, 8'h04, {16'h0, r});
      bus(1, 8'h00, {21'h0, s, p, 4'h6});
      bus(1, 8'h00, {21'h0, s, p, 4'h7});
      which <= s;
   endtask
   task print_verdict;
      $display("errors %0d checks %0d", num_errors, total_checks);
      if (num_errors == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #400000;
      num_errors++;
      print_verdict;
   end
   initial begin
      repeat (16) @(posedge clock_in);
      rst_n_in <= 1;
      rdc(8'h00, 0, "control");
      rdc(8'h04, 32'hffff, "reload");
      rdc(8'h08, 0, "count");
      rdc(8'h10, 0, "irq_en");
      rdc(8'h14, 0, "flags");
      rdc(8'h0c, 0, "unmapped");
      bus(1, 8'h10, 32'h8);
      cfg(3'h4, 4'h1, 16'h2);
      rdc(8'h08, 2, "load");
      edges(2);
      rdc(8'h08, 1, "step");
      bus(1, 8'h04, 32'h5);
      rdc(8'h08, 1, "reload_late");
      check("irq_low", 0, irq_out);
      edges(4);
      rdc(8'h08, 5, "reloaded");
      rdc(8'h14, 8, "flag_set");
      check("irq_high", 1, irq_out);
      bus(1, 8'h1c, 32'h8);
      rdc(8'h14, 8, "clear_one");
      bus(1, 8'h1c, 32'h0);
      rdc(8'h14, 0, "clear_zero");
      check("irq_clear", 0, irq_out);
      bus(1, 8'h00, {21'h0, 3'h4, 4'h1, 4'h6});
      edges(4);
      rdc(8'h08, 5, "held");
      rdc(8'h14, 0, "no_flag");
      cfg(3'h4, 4'h3, 16'h5);
      edges(7);
      rdc(8'h08, 5, "div8_wait");
      edges(1);
      rdc(8'h08, 4, "div8_tick");
      for (int s = 0; s < 5; s++) begin
         cfg(3'(s), 4'h1, 16'h5);
         edges(2);
         rdc(8'h08, 4, "selected");
         which <= 3'((s + 1) % 5);
         edges(2);
         rdc(8'h08, 4, "unselected");
      end
      cfg(3'h0, 4'h1, 16'h5);
      dbg <= 1;
      frz <= 1;
      edges(2);
      rdc(8'h08, 5, "frozen");
      frz <= 0;
      edges(2);
      rdc(8'h08, 4, "debug_run");
      dbg <= 0;
      cfg(3'h1, 4'h1, 16'h0);
      deep <= 1;
      edges(2);
      check("wakeup", 1, wakeup_out);
      bus(1, 8'h1c, 32'h0);
      cfg(3'h0, 4'h1, 16'h0);
      edges(2);
      rdc(8'h14, 0, "sleep_fast");
      deep <= 0;
      edges(2);
      rdc(8'h14, 8, "awake_fast");
      check("no_wake", 0, wakeup_out);
      bus(1, 8'h10, 32'h0);
      rdc(8'h10, 0, "irq_en_off");
      check("irq_masked", 0, irq_out);
      print_verdict;
   end
endmodule // auto_wakeup_down_timer_tb
